// ### common/mad_pkg.sv
// Purpose: shared constants and types of the multiply and auxiliary opcode decoder
// Assumes: 16-bit instruction words, one word per valid strobe
// Notes: upper-byte codes compare against bits 15 to 8 of the first word
package mad_pkg;
	localparam int MAD_WORD_W = 16;

	// Full-word fixed patterns
	localparam logic [15:0] MAD_W_ADD_PRODUCT = 16'hCE15;
	localparam logic [15:0] MAD_W_LOAD_ACC_PRODUCT = 16'hCE14;
	localparam logic [15:0] MAD_W_SUB_PRODUCT = 16'hCE16;

	// Bits 15 to 2 patterns, two-bit field below
	localparam logic [13:0] MAD_Q_SET_SHIFT = 14'h3382;
	localparam logic [13:0] MAD_Q_COMPARE_AUX = 14'h3394;

	// Upper-byte codes of memory-reference forms, and of the auxiliary add immediate, which is not one
	localparam logic [7:0] MAD_HI_MULTIPLY = 8'h38;
	localparam logic [7:0] MAD_HI_SQUARE_ACC = 8'h39;
	localparam logic [7:0] MAD_HI_MULT_ADD_PREV = 8'h3A;
	localparam logic [7:0] MAD_HI_MULT_SUB_PREV = 8'h3B;
	localparam logic [7:0] MAD_HI_LOAD_MCAND = 8'h3C;
	localparam logic [7:0] MAD_HI_LOAD_MCAND_ACC = 8'h3D;
	localparam logic [7:0] MAD_HI_LOAD_MCAND_COPY = 8'h3E;
	localparam logic [7:0] MAD_HI_LOAD_MCAND_MOVE = 8'h3F;
	localparam logic [7:0] MAD_HI_LOAD_PROD_HIGH = 8'h53;
	localparam logic [7:0] MAD_HI_SQUARE_SUB = 8'h5A;
	localparam logic [7:0] MAD_HI_LOAD_MCAND_SUB = 8'h5B;
	localparam logic [7:0] MAD_HI_MULT_ACC_MOVE = 8'h5C;
	localparam logic [7:0] MAD_HI_MULT_ACC = 8'h5D;
	localparam logic [7:0] MAD_HI_STORE_PROD_LOW = 8'h7C;
	localparam logic [7:0] MAD_HI_STORE_PROD_HIGH = 8'h7D;
	localparam logic [7:0] MAD_HI_ADD_AUX_IMM = 8'h7E;

	// Bits 15 to 11 and 15 to 9 patterns
	localparam logic [4:0] MAD_T_LOAD_AUX_SHORT = 5'h18;
	localparam logic [4:0] MAD_T_LOAD_AUX_LONG = 5'h1A;
	localparam logic [6:0] MAD_S_LOAD_PAGE = 7'h64;

	// Field positions
	localparam int MAD_IND_BIT = 7;
	localparam int MAD_AUX_SEL_LSB = 8;
	localparam int MAD_AUX_SEL_W = 3;
	localparam int MAD_OFS_W = 7;
	localparam int MAD_PAGE_W = 9;
	localparam int MAD_SHORT_W = 8;
	localparam int MAD_FLD2_W = 2;

	// Reset values
	localparam logic [15:0] MAD_IMM_RST = 16'h0000;
	localparam logic [6:0] MAD_OFS_RST = 7'h00;
	localparam logic [2:0] MAD_SEL_RST = 3'h0;
	localparam logic [1:0] MAD_FLD2_RST = 2'h0;

	typedef enum logic [4:0] {
		op_none,
		op_add_product_to_acc,
		op_load_acc_from_product,
		op_sub_product_from_acc,
		op_multiply_op,
		op_load_multiplicand,
		op_load_multiplicand_accumulate,
		op_load_mcand_acc_move,
		op_load_multiplicand_copy_product,
		op_load_mcand_subtract,
		op_mult_accumulate_long,
		op_mult_accumulate_move_long,
		op_multiply_add_previous,
		op_multiply_sub_previous,
		op_store_product_high,
		op_store_product_low,
		op_set_product_shift,
		op_square_accumulate,
		op_square_subtract,
		op_load_product_high,
		op_load_aux_long_imm,
		op_load_page_imm,
		op_compare_aux,
		op_load_aux_short_imm,
		op_add_aux_short_imm
	} mad_op_t;

	typedef enum logic {
		st_first,
		st_second
	} mad_st_t;
endpackage

// ### rtl/mad_word_classify.sv
// Purpose: combinational classification of one first instruction word
// Assumes: word is a first word, never the operand word of a two-word form
// Notes: unmatched words come out as op_none with illegal set
`timescale 1ns/10ps
module mad_word_classify
	import mad_pkg::*;
(
	input wire logic [15:0] word,
	output mad_op_t op,
	output logic two_word,
	output logic mem_ref,
	output logic illegal
);
	always_comb begin
		op = op_none;
		mem_ref = 1'b1;
		case (word[15:8])
			MAD_HI_MULTIPLY: op = op_multiply_op;
			MAD_HI_SQUARE_ACC: op = op_square_accumulate;
			MAD_HI_MULT_ADD_PREV: op = op_multiply_add_previous;
			MAD_HI_MULT_SUB_PREV: op = op_multiply_sub_previous;
			MAD_HI_LOAD_MCAND: op = op_load_multiplicand;
			MAD_HI_LOAD_MCAND_ACC: op = op_load_multiplicand_accumulate;
			MAD_HI_LOAD_MCAND_COPY: op = op_load_multiplicand_copy_product;
			MAD_HI_LOAD_MCAND_MOVE: op = op_load_mcand_acc_move;
			MAD_HI_LOAD_PROD_HIGH: op = op_load_product_high;
			MAD_HI_SQUARE_SUB: op = op_square_subtract;
			MAD_HI_LOAD_MCAND_SUB: op = op_load_mcand_subtract;
			MAD_HI_MULT_ACC_MOVE: op = op_mult_accumulate_move_long;
			MAD_HI_MULT_ACC: op = op_mult_accumulate_long;
			MAD_HI_STORE_PROD_LOW: op = op_store_product_low;
			MAD_HI_STORE_PROD_HIGH: op = op_store_product_high;
			default: mem_ref = 1'b0;
		endcase
		if (!mem_ref) begin
			if (word == MAD_W_ADD_PRODUCT) begin
				op = op_add_product_to_acc;
			end else if (word == MAD_W_LOAD_ACC_PRODUCT) begin
				op = op_load_acc_from_product;
			end else if (word == MAD_W_SUB_PRODUCT) begin
				op = op_sub_product_from_acc;
			end else if (word[15:2] == MAD_Q_SET_SHIFT) begin
				op = op_set_product_shift;
			end else if (word[15:2] == MAD_Q_COMPARE_AUX) begin
				op = op_compare_aux;
			end else if (word[15:9] == MAD_S_LOAD_PAGE) begin
				op = op_load_page_imm;
			end else if (word[15:11] == MAD_T_LOAD_AUX_SHORT) begin
				op = op_load_aux_short_imm;
			end else if (word[15:11] == MAD_T_LOAD_AUX_LONG && word[7:0] == 8'h00) begin
				op = op_load_aux_long_imm;
			end else if (word[15:8] == MAD_HI_ADD_AUX_IMM) begin
				op = op_add_aux_short_imm;
			end
		end
		two_word = (op == op_mult_accumulate_long) || (op == op_mult_accumulate_move_long) ||
			(op == op_load_aux_long_imm);
		illegal = (op == op_none);
	end
endmodule

// ### rtl/mad_decoder.sv
// Purpose: decoder of multiplier, product, multiplicand, auxiliary and page pointer instructions
// Assumes: fetch logic on clk_sys presents one word per cycle with word_valid
// Notes: decoded fields stand until the next decode; read them only while dec_valid is high
// How it works
// - CE15 decodes as add product to accumulator
// - CE14 decodes as load accumulator from product
// - CE16 decodes as subtract product from accumulator
// - Upper 38 multiply, upper 3C load multiplicand
// - Upper 3D load multiplicand and accumulate
// - Upper 3F load multiplicand, accumulate, move
// - Upper 3E load multiplicand, copy product
// - Upper 5B load multiplicand, subtract product
// - Upper 5D and 5C take two words
// - Upper 3A multiply and add previous
// - Upper 3B multiply and subtract previous
// - Upper 7D store high, 7C store low
// - Shift mode set from bits 1 to 0
// - Upper 39 square-accumulate, 5A square-subtract
// - Upper 53 loads product high half
// - Long auxiliary load takes second word
// - Page pointer load from nine-bit immediate
// - Compare auxiliary with register zero, condition field
// - Short auxiliary load, select and byte
// - Upper 7E adds byte to auxiliary
`timescale 1ns/10ps
module mad_decoder
	import mad_pkg::*;
#(
	parameter int WORD_W = MAD_WORD_W
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic word_valid,
	input wire logic [15:0] word_in,
	output logic dec_valid,
	output mad_op_t dec_op,
	output logic dec_two_word,
	output logic dec_illegal,
	output logic dec_wait_second,
	output logic dec_mem_ref,
	output logic dec_indirect,
	output logic [6:0] dec_dir_offset,
	output logic [6:0] dec_ind_mode,
	output logic [2:0] dec_aux_sel,
	output logic [15:0] dec_imm,
	output logic [1:0] dec_field2
);
	// Only 16-bit words are decoded
	if (WORD_W != MAD_WORD_W) begin : g_word_w_chk
		$error("mad_decoder serves 16-bit words only");
	end

	// Whole decoder state in one register
	typedef struct packed {
		mad_st_t st;
		logic valid;
		mad_op_t op;
		logic two_word;
		logic illegal;
		logic mem_ref;
		logic indirect;
		logic [6:0] dir_offset;
		logic [6:0] ind_mode;
		logic [2:0] aux_sel;
		logic [15:0] imm;
		logic [1:0] field2;
	} mad_state_t;

	localparam mad_state_t MAD_STATE_RST = '{
		st: st_first,
		valid: 1'b0,
		op: op_none,
		two_word: 1'b0,
		illegal: 1'b0,
		mem_ref: 1'b0,
		indirect: 1'b0,
		dir_offset: MAD_OFS_RST,
		ind_mode: MAD_OFS_RST,
		aux_sel: MAD_SEL_RST,
		imm: MAD_IMM_RST,
		field2: MAD_FLD2_RST
	};

	mad_state_t s_r;
	mad_state_t s_nxt;
	mad_op_t cls_op;
	logic cls_two_word;
	logic cls_mem_ref;
	logic cls_illegal;
	logic take_first;
	logic take_second;

	// Pattern match of a first word
	mad_word_classify u_classify (
		.word(word_in),
		.op(cls_op),
		.two_word(cls_two_word),
		.mem_ref(cls_mem_ref),
		.illegal(cls_illegal)
	);

	assign take_first = word_valid && (s_r.st == st_first);
	assign take_second = word_valid && (s_r.st == st_second);

	// Operand word is never decoded as an opcode
	always_comb begin
		s_nxt = s_r;
		s_nxt.valid = 1'b0;
		case (s_r.st)
			st_first: begin
				if (word_valid) begin
					s_nxt.op = cls_op;
					s_nxt.two_word = cls_two_word;
					s_nxt.illegal = cls_illegal;
					s_nxt.mem_ref = cls_mem_ref;
					s_nxt.indirect = cls_mem_ref && word_in[MAD_IND_BIT];
					s_nxt.dir_offset = (cls_mem_ref && !word_in[MAD_IND_BIT]) ? word_in[MAD_OFS_W-1:0] :
						MAD_OFS_RST;
					s_nxt.ind_mode = (cls_mem_ref && word_in[MAD_IND_BIT]) ? word_in[MAD_OFS_W-1:0] :
						MAD_OFS_RST;
					s_nxt.aux_sel = MAD_SEL_RST;
					s_nxt.imm = MAD_IMM_RST;
					s_nxt.field2 = MAD_FLD2_RST;
					case (cls_op)
						op_set_product_shift, op_compare_aux: begin
							s_nxt.field2 = word_in[MAD_FLD2_W-1:0];
						end
						op_load_page_imm: begin
							s_nxt.imm = {7'h00, word_in[MAD_PAGE_W-1:0]};
						end
						op_load_aux_short_imm: begin
							s_nxt.aux_sel = word_in[MAD_AUX_SEL_LSB +: MAD_AUX_SEL_W];
							s_nxt.imm = {8'h00, word_in[MAD_SHORT_W-1:0]};
						end
						op_add_aux_short_imm: begin
							s_nxt.imm = {8'h00, word_in[MAD_SHORT_W-1:0]};
						end
						op_load_aux_long_imm: begin
							s_nxt.aux_sel = word_in[MAD_AUX_SEL_LSB +: MAD_AUX_SEL_W];
						end
						default: begin
							s_nxt.field2 = MAD_FLD2_RST;
						end
					endcase
					if (cls_two_word) begin
						s_nxt.st = st_second;
					end else begin
						s_nxt.valid = 1'b1;
					end
				end
			end
			st_second: begin
				if (word_valid) begin
					s_nxt.imm = word_in;
					s_nxt.valid = 1'b1;
					s_nxt.st = st_first;
				end
			end
			default: begin
				s_nxt = MAD_STATE_RST;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_r <= MAD_STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dec_valid = s_r.valid;
	assign dec_op = s_r.op;
	assign dec_two_word = s_r.two_word;
	assign dec_illegal = s_r.illegal;
	assign dec_wait_second = (s_r.st == st_second);
	assign dec_mem_ref = s_r.mem_ref;
	assign dec_indirect = s_r.indirect;
	assign dec_dir_offset = s_r.dir_offset;
	assign dec_ind_mode = s_r.ind_mode;
	assign dec_aux_sel = s_r.aux_sel;
	assign dec_imm = s_r.imm;
	assign dec_field2 = s_r.field2;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	add_product_to_acc_decode_a: assert property (
		take_first && word_in == MAD_W_ADD_PRODUCT |=> dec_valid && dec_op == op_add_product_to_acc && !dec_illegal)
		else $error("product add word not decoded");
	pac_decode_a: assert property (
		take_first && word_in == MAD_W_LOAD_ACC_PRODUCT |=> dec_valid && dec_op == op_load_acc_from_product)
		else $error("product load word not decoded");
	sub_product_from_acc_decode_a: assert property (
		take_first && word_in == MAD_W_SUB_PRODUCT |=> dec_valid && dec_op == op_sub_product_from_acc)
		else $error("product subtract word not decoded");
	mult_load_a: assert property (
		take_first && (word_in[15:8] == MAD_HI_MULTIPLY || word_in[15:8] == MAD_HI_LOAD_MCAND) |=>
		dec_valid && dec_mem_ref &&
		dec_op == ($past(word_in[15:8]) == MAD_HI_MULTIPLY ? op_multiply_op : op_load_multiplicand))
		else $error("multiply or multiplicand load misdecoded");
	mcand_acc_a: assert property (
		take_first && word_in[15:8] == MAD_HI_LOAD_MCAND_ACC |=> dec_valid && dec_op == op_load_multiplicand_accumulate)
		else $error("multiplicand load with accumulate misdecoded");
	mcand_move_a: assert property (
		take_first && word_in[15:8] == MAD_HI_LOAD_MCAND_MOVE |=> dec_valid && dec_op == op_load_mcand_acc_move)
		else $error("multiplicand load with move misdecoded");
	mcand_copy_a: assert property (
		take_first && word_in[15:8] == MAD_HI_LOAD_MCAND_COPY |=>
		dec_valid && dec_op == op_load_multiplicand_copy_product)
		else $error("multiplicand load with copy misdecoded");
	mcand_sub_a: assert property (
		take_first && word_in[15:8] == MAD_HI_LOAD_MCAND_SUB |=> dec_valid && dec_op == op_load_mcand_subtract)
		else $error("multiplicand load with subtract misdecoded");
	long_mac_a: assert property (
		take_first && (word_in[15:8] == MAD_HI_MULT_ACC || word_in[15:8] == MAD_HI_MULT_ACC_MOVE) |=>
		!dec_valid && dec_wait_second && dec_two_word)
		else $error("two-word multiply-accumulate did not wait for second word");
	second_word_a: assert property (
		take_second |=> dec_valid && dec_imm == $past(word_in) && !dec_wait_second)
		else $error("second word not captured as operand");
	mult_prev_a: assert property (
		take_first && word_in[15:8] == MAD_HI_MULT_ADD_PREV |=> dec_valid && dec_op == op_multiply_add_previous)
		else $error("multiply with add misdecoded");
	mult_subprev_a: assert property (
		take_first && word_in[15:8] == MAD_HI_MULT_SUB_PREV |=> dec_valid && dec_op == op_multiply_sub_previous)
		else $error("multiply with subtract misdecoded");
	store_prod_a: assert property (
		take_first && word_in[15:9] == MAD_HI_STORE_PROD_LOW[7:1] |=> dec_valid &&
		dec_op == ($past(word_in[8]) ? op_store_product_high : op_store_product_low))
		else $error("product store half misdecoded");
	shift_mode_a: assert property (
		take_first && word_in[15:2] == MAD_Q_SET_SHIFT |=> dec_op == op_set_product_shift &&
		dec_field2 == $past(word_in[1:0]))
		else $error("shift mode field not extracted");
	square_a: assert property (
		take_first && word_in[15:8] == MAD_HI_SQUARE_ACC |=> dec_op == op_square_accumulate && dec_mem_ref)
		else $error("square accumulate misdecoded");
	square_sub_a: assert property (
		take_first && word_in[15:8] == MAD_HI_SQUARE_SUB |=> dec_op == op_square_subtract && dec_mem_ref)
		else $error("square subtract misdecoded");
	prod_high_a: assert property (
		take_first && word_in[15:8] == MAD_HI_LOAD_PROD_HIGH |=> dec_valid && dec_op == op_load_product_high)
		else $error("product high load misdecoded");
	long_aux_a: assert property (
		take_first && word_in[15:11] == MAD_T_LOAD_AUX_LONG && word_in[7:0] == 8'h00 |=>
		dec_wait_second && dec_op == op_load_aux_long_imm && dec_aux_sel == $past(word_in[10:8]))
		else $error("long auxiliary load misdecoded");
	page_imm_a: assert property (
		take_first && word_in[15:9] == MAD_S_LOAD_PAGE |=> dec_op == op_load_page_imm &&
		dec_imm == {7'h00, $past(word_in[8:0])})
		else $error("page pointer immediate misdecoded");
	compare_a: assert property (
		take_first && word_in[15:2] == MAD_Q_COMPARE_AUX |=> dec_op == op_compare_aux &&
		dec_field2 == $past(word_in[1:0]))
		else $error("auxiliary compare misdecoded");
	short_aux_a: assert property (
		take_first && word_in[15:11] == MAD_T_LOAD_AUX_SHORT |=> dec_op == op_load_aux_short_imm &&
		dec_aux_sel == $past(word_in[10:8]) && dec_imm == {8'h00, $past(word_in[7:0])})
		else $error("short auxiliary load misdecoded");
	addr_mode_a: assert property (
		take_first && cls_mem_ref |=> dec_indirect == $past(word_in[7]) &&
		(dec_indirect ? dec_ind_mode == $past(word_in[6:0]) : dec_dir_offset == $past(word_in[6:0])))
		else $error("addressing mode fields wrong");
	unmatched_a: assert property (
		take_first && cls_op == op_none |=> dec_valid && dec_illegal && dec_op == op_none && !dec_wait_second)
		else $error("unmatched word not flagged");
	add_aux_a: assert property (
		take_first && word_in[15:8] == MAD_HI_ADD_AUX_IMM |=> dec_op == op_add_aux_short_imm &&
		dec_imm == {8'h00, $past(word_in[7:0])})
		else $error("auxiliary add immediate misdecoded");

	// Handshake, reset and field checks
	one_word_a: assert property (
		take_first && word_in[15:8] != MAD_HI_MULT_ACC && word_in[15:8] != MAD_HI_MULT_ACC_MOVE &&
		!(word_in[15:11] == MAD_T_LOAD_AUX_LONG && word_in[7:0] == 8'h00) |=>
		dec_valid && !dec_two_word && !dec_wait_second)
		else $error("one-word instruction did not complete");
	idle_hold_a: assert property (
		!word_valid |=> !dec_valid && $stable(dec_op) && $stable(dec_imm) && $stable(dec_wait_second))
		else $error("result changed without a word");
	wait_hold_a: assert property (
		dec_wait_second && !word_valid |=> dec_wait_second && !dec_valid)
		else $error("second word wait dropped");
	fields_zero_a: assert property (
		take_first && cls_mem_ref |=>
		dec_aux_sel == MAD_SEL_RST && dec_field2 == MAD_FLD2_RST && dec_imm == MAD_IMM_RST)
		else $error("unused fields of a memory-reference word not cleared");
	rst_clear_a: assert property (disable iff (1'b0)
		sys_rst |=> !dec_valid && !dec_wait_second && !dec_illegal && dec_op == op_none)
		else $error("reset did not clear the decoder");
	illegal_op_a: assert property (
		dec_valid && dec_illegal |-> dec_op == op_none && !dec_two_word && !dec_mem_ref)
		else $error("flagged word carries an opcode");
	ind_excl_a: assert property (
		dec_valid && dec_indirect |-> dec_mem_ref && dec_dir_offset == MAD_OFS_RST)
		else $error("indirect word kept a direct offset");

	// Main scenarios
	long_mac_c: cover property (take_first && word_in[15:8] == MAD_HI_MULT_ACC ##[1:4] take_second ##1 dec_valid);
	long_aux_c: cover property (take_first && cls_op == op_load_aux_long_imm ##1 take_second ##1 dec_valid);
	illegal_c: cover property (dec_valid && dec_illegal);
	indirect_c: cover property (dec_valid && dec_indirect ##1 dec_valid && !dec_indirect && dec_mem_ref);
	wait_gap_c: cover property (dec_wait_second && !word_valid ##1 take_second ##1 dec_valid);
endmodule

// ### verification/mad_fetch_model.sv
// Purpose: program fetch side that offers instruction words to the decoder
// Assumes: words change on the falling edge of clk_sys, one word per high cycle of word_valid
// Notes: between words the bus inverts once per idle cycle, so after an even number of idle cycles it shows the last word again
`timescale 1ns/10ps
module mad_fetch_model (
	input wire logic clk_sys,
	output logic word_valid,
	output logic [15:0] word_in
);
	initial begin
		word_valid = 1'b0;
		word_in = 16'h0000;
	end

	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk_sys);
			word_valid = 1'b0;
			word_in = ~word_in;
		end
	endtask

	// Word stays offered until the next call changes it
	task automatic send(input logic [15:0] w, input int gap);
		idle(gap);
		@(negedge clk_sys);
		word_valid = 1'b1;
		word_in = w;
	endtask
endmodule

// ### verification/testbench.sv
// Purpose: self-checking bench of the multiply and auxiliary opcode decoder
// Assumes: decoded results arrive in the order their words were offered
// Notes: expected fields packed as op, two_word, illegal, mem_ref, indirect, offsets, sel, imm, field2
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
	import mad_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic word_valid, dec_valid, dec_two_word, dec_illegal, dec_wait_second, dec_mem_ref, dec_indirect;
	logic [15:0] word_in, dec_imm;
	mad_op_t dec_op;
	logic [6:0] dec_dir_offset, dec_ind_mode;
	logic [2:0] dec_aux_sel;
	logic [1:0] dec_field2;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [43:0] exp_q[$];
	logic [15:0] tbl_base[29] = '{16'h3800, 16'h3900, 16'h3A00, 16'h3B00, 16'h3C00, 16'h3D00, 16'h3E00,
		16'h3F00, 16'h5300, 16'h5A00, 16'h5B00, 16'h5C00, 16'h5D00, 16'h7C00, 16'h7D00, 16'h7E00,
		16'hCE15, 16'hCE14, 16'hCE16, 16'hCE08, 16'hCE50, 16'hC000, 16'hC800, 16'hD000,
		16'hFFFF, 16'hD001, 16'h0000, 16'hCE17, 16'hCE0C};
	logic [15:0] tbl_mask[29] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF,
		16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF,
		16'h0000, 16'h0000, 16'h0000, 16'h0003, 16'h0003, 16'h07FF, 16'h01FF, 16'h0700,
		16'h0000, 16'h0700, 16'h0000, 16'h0000, 16'h0003};

	always #10 clk_sys = ~clk_sys;

	mad_fetch_model i_fetch (.clk_sys(clk_sys), .word_valid(word_valid), .word_in(word_in));

	mad_decoder i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .word_valid(word_valid), .word_in(word_in),
		.dec_valid(dec_valid), .dec_op(dec_op), .dec_two_word(dec_two_word), .dec_illegal(dec_illegal),
		.dec_wait_second(dec_wait_second), .dec_mem_ref(dec_mem_ref), .dec_indirect(dec_indirect),
		.dec_dir_offset(dec_dir_offset), .dec_ind_mode(dec_ind_mode), .dec_aux_sel(dec_aux_sel),
		.dec_imm(dec_imm), .dec_field2(dec_field2));

	function automatic logic [43:0] exp_dec(input logic [15:0] w, input logic [15:0] w2);
		mad_op_t op;
		logic mr;
		logic tw;
		logic [2:0] sel;
		logic [15:0] imm;
		logic [1:0] f2;
		mr = 1'b1;
		case (w[15:8])
			8'h38: op = op_multiply_op;
			8'h3C: op = op_load_multiplicand;
			8'h3D: op = op_load_multiplicand_accumulate;
			8'h3F: op = op_load_mcand_acc_move;
			8'h3E: op = op_load_multiplicand_copy_product;
			8'h5B: op = op_load_mcand_subtract;
			8'h5D: op = op_mult_accumulate_long;
			8'h5C: op = op_mult_accumulate_move_long;
			8'h3A: op = op_multiply_add_previous;
			8'h3B: op = op_multiply_sub_previous;
			8'h7D: op = op_store_product_high;
			8'h7C: op = op_store_product_low;
			8'h39: op = op_square_accumulate;
			8'h5A: op = op_square_subtract;
			8'h53: op = op_load_product_high;
			default: begin
				mr = 1'b0;
				op = op_none;
			end
		endcase
		if (!mr) begin
			if (w == 16'hCE15) op = op_add_product_to_acc;
			else if (w == 16'hCE14) op = op_load_acc_from_product;
			else if (w == 16'hCE16) op = op_sub_product_from_acc;
			else if (w[15:2] == 14'h3382) op = op_set_product_shift;
			else if (w[15:2] == 14'h3394) op = op_compare_aux;
			else if (w[15:11] == 5'h1A && w[7:0] == 8'h00) op = op_load_aux_long_imm;
			else if (w[15:9] == 7'h64) op = op_load_page_imm;
			else if (w[15:11] == 5'h18) op = op_load_aux_short_imm;
			else if (w[15:8] == 8'h7E) op = op_add_aux_short_imm;
		end
		tw = op inside {op_mult_accumulate_long, op_mult_accumulate_move_long, op_load_aux_long_imm};
		f2 = (op == op_set_product_shift || op == op_compare_aux) ? w[1:0] : 2'h0;
		sel = (op == op_load_aux_long_imm || op == op_load_aux_short_imm) ? w[10:8] : 3'h0;
		if (tw) imm = w2;
		else if (op == op_load_aux_short_imm || op == op_add_aux_short_imm) imm = {8'h00, w[7:0]};
		else if (op == op_load_page_imm) imm = {7'h00, w[8:0]};
		else imm = 16'h0000;
		return {op, tw, op == op_none, mr, mr & w[7], (mr & !w[7]) ? w[6:0] : 7'h00,
			(mr & w[7]) ? w[6:0] : 7'h00, sel, imm, f2};
	endfunction

	// Offers one instruction, a second word too when the form takes one
	task automatic put(input logic [15:0] w, input logic [15:0] w2, input int gap);
		logic [43:0] e;
		e = exp_dec(w, w2);
		i_fetch.send(w, gap);
		if (e[38]) begin
			@(posedge clk_sys);
			#1;
			`CHK({dec_wait_second, dec_valid}, 2'b10)
			i_fetch.send(w2, gap);
		end
		exp_q.push_back(e);
	endtask

	task automatic do_reset(input int n);
		i_fetch.idle(1);
		sys_rst = 1'b1;
		repeat (n) @(negedge clk_sys);
		sys_rst = 1'b0;
	endtask

	task automatic drain();
		i_fetch.idle(1);
		repeat (20) if (exp_q.size() != 0) @(posedge clk_sys);
		`CHK(exp_q.size(), 0)
	endtask

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		if (!sys_rst && dec_valid === 1'b1) begin
			logic [43:0] e;
			e = (exp_q.size() != 0) ? exp_q.pop_front() : {44{1'bx}};
			`CHK({dec_op, dec_two_word, dec_illegal, dec_mem_ref, dec_indirect, dec_dir_offset, dec_ind_mode,
				dec_aux_sel, dec_imm, dec_field2}, e)
		end
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			final_report();
		end
	end

	initial begin
		logic [15:0] w;
		int k;
		void'($urandom(38685));
		repeat (20) @(negedge clk_sys);
		sys_rst = 1'b0;
		`CHK({dec_valid, dec_wait_second, dec_op}, {2'b00, op_none})
		for (int pass = 0; pass < 2; pass++) begin
			for (int i = 0; i < 29; i++) begin
				w = tbl_base[i] | (16'($urandom) & tbl_mask[i]);
				if (tbl_mask[i][7]) w[7] = pass[0];
				put(w, 16'($urandom), i % 2);
			end
		end
		drain();
		$display("table test done");
		put(16'h5D00, 16'hCE15, 0);
		put(16'hD300, 16'h5C80, 0);
		put(16'hCE15, 16'h0000, 0);
		drain();
		$display("operand word test done");
		i_fetch.send(16'h5D85, 0);
		@(posedge clk_sys);
		#1;
		`CHK(dec_wait_second, 1'b1)
		do_reset(2);
		#1;
		`CHK({dec_valid, dec_wait_second, dec_op}, {2'b00, op_none})
		put(16'hCE16, 16'h0000, 0);
		drain();
		$display("reset abort test done");
		for (int i = 0; i < 300; i++) begin
			k = $urandom_range(28, 0);
			w = (i % 2 == 0) ? (tbl_base[k] | (16'($urandom) & tbl_mask[k])) : 16'($urandom);
			put(w, 16'($urandom), $urandom_range(2, 0));
		end
		drain();
		$display("random stream test done");
		final_report();
	end
endmodule
